// [hw/baud_gen_regs.svh]
// Register map, field positions, reset values and divider counts of the bit-rate generator
`ifndef BAUD_GEN_REGS_SVH
`define BAUD_GEN_REGS_SVH

// ==========================================================
// Register byte offsets
`define OFS_SERIAL_CTRL     8'h00
`define OFS_POWER_CTRL      8'h04
`define OFS_TIMER_MODE      8'h08
`define OFS_T1_RELOAD_HIGH  8'h0c
`define OFS_T1_RUN_CTRL     8'h10
`define OFS_T2_CTRL         8'h14
`define OFS_CAP_RELOAD_LOW  8'h18
`define OFS_CAP_RELOAD_HIGH 8'h1c
`define OFS_FRAC_CTRL       8'h20
`define OFS_FRAC_DIVIDE     8'h24
`define OFS_PLL_DIVIDER     8'h28
`define OFS_STATUS          8'h2c

// ==========================================================
// Register indices, writable count, masks and reset values
`define IDX_SERIAL_CTRL     4'h0
`define IDX_POWER_CTRL      4'h1
`define IDX_TIMER_MODE      4'h2
`define IDX_T1_RELOAD_HIGH  4'h3
`define IDX_T1_RUN_CTRL     4'h4
`define IDX_T2_CTRL         4'h5
`define IDX_CAP_RELOAD_LOW  4'h6
`define IDX_CAP_RELOAD_HIGH 4'h7
`define IDX_FRAC_CTRL       4'h8
`define IDX_FRAC_DIVIDE     4'h9
`define IDX_PLL_DIVIDER     4'ha
`define IDX_STATUS          4'hb
`define IDX_NONE            4'hf
`define NUM_RW_REGS         11
`define REG_WR_MASKS        88'h07_ff_87_ff_ff_34_01_ff_f0_80_c0
`define REG_RESETS          88'h00_00_00_00_00_00_00_00_00_00_00

// ==========================================================
// Field positions
`define SMODE_HI_BIT        7
`define SMODE_LO_BIT        6
`define RATE_DOUBLE_BIT     7
`define T1_COUNTER_BIT      6
`define T1_MODE_HI_BIT      5
`define T1_MODE_LO_BIT      4
`define T1_RUN_BIT          0
`define T2_RX_CLK_BIT       5
`define T2_TX_CLK_BIT       4
`define T2_RUN_BIT          2
`define FRAC_EN_BIT         7
`define BIN_DIV_HI_BIT      2
`define CORE_DIV_HI_BIT     2

// ==========================================================
// Divider counts (terminal value is divide ratio minus one), then fractional base and step
`define MACH_LIMIT          16'h000b
`define M2_FAST_LIMIT       16'h001f
`define M2_SLOW_LIMIT       16'h003f
`define T1_POST_FAST        16'h000f
`define T1_POST_SLOW        16'h001f
`define T1_M0_LIMIT         16'h1fff
`define T1_M1_LIMIT         16'hffff
`define T2_PRE_LIMIT        16'h0001
`define T2_POST_LIMIT       16'h000f
`define FRAC_BASE           9'h040
`define FRAC_STEP           9'h002

`endif

// [hw/baud_gen_pkg.sv]
// Types shared by the bit-rate generator and its register bus
package baud_gen_pkg;

    // ==========================================================
    // Avalon-MM request and answer
    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avs_req_s;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } avs_rsp_s;

    // ==========================================================
    // Bit-rate ticks per direction
    typedef struct packed {
        logic tx;
        logic rx;
    } bit_tick_s;

    // ==========================================================
    // Serial modes, tick sources and bus states
    typedef enum logic [1:0] {
        MODE_SHIFT = 2'b00,
        MODE_UART8 = 2'b01,
        MODE_FIXED9 = 2'b10,
        MODE_UART9 = 2'b11
    } serial_mode_e;

    typedef enum logic [2:0] {
        SRC_MACH  = 3'b000,
        SRC_MODE2 = 3'b001,
        SRC_T1    = 3'b010,
        SRC_T2    = 3'b011,
        SRC_FRAC  = 3'b100
    } rate_src_e;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ACK  = 1'b1
    } bus_state_e;

endpackage

// [hw/tick_divider.sv]
// Counter that pulses once every limit+1 steps, used for all prescalers and timers
module tick_divider (
    // Clock, reset and freeze
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_clk_en,
    // Count event and terminal value
    input  wire logic        i_step,
    input  wire logic [15:0] i_limit,
    // Terminal pulse
    output var  logic        o_tick
);
    logic [15:0] cnt;
    logic        at_end;

    // Terminal test also catches a limit lowered below the count
    assign at_end = (cnt >= i_limit);
    assign o_tick = i_clk_en & i_step & at_end;

    // Count steps and restart from zero at the terminal value
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            cnt <= 16'h0000;
        end else if (i_clk_en && i_step) begin
            cnt <= at_end ? 16'h0000 : cnt + 16'h0001;
        end
    end
endmodule

// [hw/baud_rate_gen.sv]
// Bit-rate generator with Avalon-MM registers, timers and fractional divider
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`include "baud_gen_regs.svh"

module baud_rate_gen (
    // Clock, reset and freeze
    input  wire logic                    i_ref_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_clk_en,
    // Avalon-MM register slave
    input  wire baud_gen_pkg::avs_req_s  i_avs,
    output var  baud_gen_pkg::avs_rsp_s  o_avs,
    // Timer 1 external count input
    input  wire logic                    i_t1_count_in,
    // Bit-rate ticks to the shift logic
    output var  baud_gen_pkg::bit_tick_s o_tick
);
    import baud_gen_pkg::*;

    // ==========================================================
    // Divider slots
    localparam int D_CORE = 0;
    localparam int D_MACH = 1;
    localparam int D_M2   = 2;
    localparam int D_T1   = 3;
    localparam int D_T1P  = 4;
    localparam int D_T2P  = 5;
    localparam int D_T2   = 6;
    localparam int D_T2Q  = 7;
    localparam int D_BIN  = 8;
    localparam int N_DIV  = 9;

    logic [7:0]   regs [0:`NUM_RW_REGS-1];
    logic [7:0]   rdata_q;
    bus_state_e   bus_state;
    logic         req;
    logic         wait_c;
    logic         t1_pin_q;
    logic [8:0]   frac_acc;
    logic [8:0]   frac_sum;
    logic [8:0]   frac_limit;
    logic         frac_wrap;
    logic         frac_tick;
    logic         div_step  [0:N_DIV-1];
    logic [15:0]  div_limit [0:N_DIV-1];
    logic         div_tick  [0:N_DIV-1];
    serial_mode_e serial_mode;
    logic         frac_en;
    logic         rate_double_bit_eff;
    logic         tx_clock_select_eff;
    logic         rclk_eff;
    logic [1:0]   t1_mode;
    logic         t1_run;
    logic         t1_fall;
    logic [15:0]  t1_limit;
    logic [3:0]   bus_idx;
    logic [4:0]   src_ticks;
    rate_src_e    tx_src;
    rate_src_e    rx_src;

    // ==========================================================
    // Decoding helpers
    function automatic logic [3:0] reg_index(input logic [7:0] addr);
        logic [3:0] idx;
        idx = `IDX_NONE;
        if (addr[1:0] == 2'b00 && addr <= `OFS_STATUS) begin
            idx = addr[5:2];
        end
        return idx;
    endfunction

    function automatic logic pick_tick(input rate_src_e src, input logic [4:0] t);
        logic v;
        v = 1'b0;
        unique case (src)
            SRC_MACH:  v = t[0];
            SRC_MODE2: v = t[1];
            SRC_T1:    v = t[2];
            SRC_T2:    v = t[3];
            SRC_FRAC:  v = t[4];
            default:   v = 1'b0;
        endcase
        return v;
    endfunction

    // ==========================================================
    // Register fields
    assign serial_mode = serial_mode_e'({regs[`IDX_SERIAL_CTRL][`SMODE_HI_BIT],
                                         regs[`IDX_SERIAL_CTRL][`SMODE_LO_BIT]});
    assign frac_en  = regs[`IDX_FRAC_CTRL][`FRAC_EN_BIT];
    // Fractional enable masks doubling and clock selects
    assign rate_double_bit_eff = regs[`IDX_POWER_CTRL][`RATE_DOUBLE_BIT] & ~frac_en;
    assign tx_clock_select_eff = regs[`IDX_T2_CTRL][`T2_TX_CLK_BIT] & ~frac_en;
    assign rclk_eff = regs[`IDX_T2_CTRL][`T2_RX_CLK_BIT] & ~frac_en;
    assign t1_mode  = {regs[`IDX_TIMER_MODE][`T1_MODE_HI_BIT],
                       regs[`IDX_TIMER_MODE][`T1_MODE_LO_BIT]};
    assign t1_run   = regs[`IDX_T1_RUN_CTRL][`T1_RUN_BIT];

    // ==========================================================
    // Avalon-MM slave: one wait cycle, then answer
    assign req    = i_avs.read | i_avs.write;
    assign wait_c = req & ~(bus_state == BUS_ACK && i_clk_en);
    assign o_avs  = '{waitrequest: wait_c, readdata: {24'h000000, rdata_q}};
    // Register slot of the current address, shared by reads and writes
    assign bus_idx = reg_index(i_avs.address);

    // Bus state: idle to answer and back
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            bus_state <= BUS_IDLE;
        end else if (i_clk_en) begin
            unique case (bus_state)
                BUS_IDLE: bus_state <= req ? BUS_ACK : BUS_IDLE;
                BUS_ACK:  bus_state <= BUS_IDLE;
            endcase
        end
    end

    // Read data captured while waiting, unmapped reads give zero
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_q <= 8'h00;
        end else if (i_clk_en && bus_state == BUS_IDLE && i_avs.read) begin
            if (bus_idx < 4'(`NUM_RW_REGS)) begin
                rdata_q <= regs[bus_idx];
            end else if (bus_idx == `IDX_STATUS) begin
                rdata_q <= {2'b00, rx_src, tx_src};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // Register writes land at the answering edge, reserved bits stay zero
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            for (int i = 0; i < `NUM_RW_REGS; i++) begin
                regs[i] <= 8'(`REG_RESETS >> (8 * i));
            end
        end else if (i_clk_en && bus_state == BUS_ACK && i_avs.write &&
                     i_avs.byteenable[0] && bus_idx < 4'(`NUM_RW_REGS)) begin
            regs[bus_idx] <= i_avs.writedata[7:0] & 8'(`REG_WR_MASKS >> (8 * bus_idx));
        end
    end

    // ==========================================================
    // Divider chain
    // Core clock after the PLL divider, 2^CD reference clocks
    assign div_step[D_CORE]  = 1'b1;
    assign div_limit[D_CORE] = (16'h0001 << regs[`IDX_PLL_DIVIDER][`CORE_DIV_HI_BIT:0])
                               - 16'h0001;
    // Machine cycle, twelve core clocks
    assign div_step[D_MACH]  = div_tick[D_CORE];
    assign div_limit[D_MACH] = `MACH_LIMIT;
    // Mode 2 fixed rate
    assign div_step[D_M2]    = div_tick[D_CORE];
    assign div_limit[D_M2]   = rate_double_bit_eff ? `M2_FAST_LIMIT : `M2_SLOW_LIMIT;

    // Timer 1 counts machine cycles or falling edges of its input
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            t1_pin_q <= 1'b0;
        end else if (i_clk_en) begin
            t1_pin_q <= i_t1_count_in;
        end
    end
    assign t1_fall         = t1_pin_q & ~i_t1_count_in;
    assign div_step[D_T1]  = t1_run && t1_mode != 2'b11 &&
                             (regs[`IDX_TIMER_MODE][`T1_COUNTER_BIT] ? t1_fall
                                                                     : div_tick[D_MACH]);
    // Timer 1 overflow period per running mode
    always_comb begin
        unique case (t1_mode)
            2'b00:   t1_limit = `T1_M0_LIMIT;
            2'b01:   t1_limit = `T1_M1_LIMIT;
            2'b10:   t1_limit = {8'h00, 8'hff - regs[`IDX_T1_RELOAD_HIGH]};
            2'b11:   t1_limit = `T1_M1_LIMIT;
        endcase
    end
    assign div_limit[D_T1] = t1_limit;
    // Timer 1 overflows to bits: 2^RATE_DOUBLE_BIT over 32
    assign div_step[D_T1P]  = div_tick[D_T1];
    assign div_limit[D_T1P] = rate_double_bit_eff ? `T1_POST_FAST : `T1_POST_SLOW;

    // Timer 2 steps every two core clocks in bit-rate mode
    assign div_step[D_T2P]  = div_tick[D_CORE] & regs[`IDX_T2_CTRL][`T2_RUN_BIT] &
                              (tx_clock_select_eff | rclk_eff);
    assign div_limit[D_T2P] = `T2_PRE_LIMIT;
    // Timer 2 autoreload from the capture pair
    assign div_step[D_T2]   = div_tick[D_T2P];
    assign div_limit[D_T2]  = 16'hffff - {regs[`IDX_CAP_RELOAD_HIGH],
                                          regs[`IDX_CAP_RELOAD_LOW]};
    // Sixteen Timer 2 overflows per bit
    assign div_step[D_T2Q]  = div_tick[D_T2];
    assign div_limit[D_T2Q] = `T2_POST_LIMIT;
    // Fractional timer binary pre-divider 2^DIV
    assign div_step[D_BIN]  = div_tick[D_CORE] & frac_en;
    assign div_limit[D_BIN] = (16'h0001 << regs[`IDX_FRAC_CTRL][`BIN_DIV_HI_BIT:0])
                              - 16'h0001;

    // One divider per slot
    generate
        for (genvar g = 0; g < N_DIV; g++) begin : g_div
            tick_divider u_div (
                .i_ref_clk (i_ref_clk),
                .i_sys_rst (i_sys_rst),
                .i_clk_en  (i_clk_en),
                .i_step    (div_step[g]),
                .i_limit   (div_limit[g]),
                .o_tick    (div_tick[g])
            );
        end
    endgenerate

    // ==========================================================
    // Fractional divider: add two per pre-divided clock, wrap at fd+64
    assign frac_limit = {1'b0, regs[`IDX_FRAC_DIVIDE]} + `FRAC_BASE;
    assign frac_sum   = frac_acc + `FRAC_STEP;
    assign frac_wrap  = frac_sum >= frac_limit;
    assign frac_tick  = div_tick[D_BIN] & frac_wrap;

    // Accumulator keeps the remainder so the average rate is exact
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            frac_acc <= 9'h000;
        end else if (i_clk_en && div_tick[D_BIN]) begin
            frac_acc <= frac_wrap ? frac_sum - frac_limit : frac_sum;
        end
    end

    // ==========================================================
    // Source selection per direction
    always_comb begin
        tx_src = SRC_MACH;
        rx_src = SRC_MACH;
        unique case (serial_mode)
            MODE_SHIFT: begin
                tx_src = SRC_MACH;
                rx_src = SRC_MACH;
            end
            MODE_FIXED9: begin
                tx_src = SRC_MODE2;
                rx_src = SRC_MODE2;
            end
            MODE_UART8, MODE_UART9: begin
                if (frac_en) begin
                    tx_src = SRC_FRAC;
                    rx_src = SRC_FRAC;
                end else begin
                    tx_src = tx_clock_select_eff ? SRC_T2 : SRC_T1;
                    rx_src = rclk_eff ? SRC_T2 : SRC_T1;
                end
            end
        endcase
    end

    // Candidate source pulses, in source code order
    assign src_ticks = {frac_tick, div_tick[D_T2Q], div_tick[D_T1P], div_tick[D_M2],
                        div_tick[D_MACH]};

    // Registered ticks, one per direction
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_tick <= '0;
        end else if (i_clk_en) begin
            o_tick.tx <= pick_tick(tx_src, src_ticks);
            o_tick.rx <= pick_tick(rx_src, src_ticks);
        end
    end

    // ==========================================================
    // Checks
    property p_mode0_tick;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (serial_mode == MODE_SHIFT && div_tick[D_MACH]) |=> (o_tick.tx && o_tick.rx);
    endproperty
    a_mode0_tick: assert property (p_mode0_tick) else $error("mode 0 tick missing");

    property p_mode2_div;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (serial_mode == MODE_FIXED9) |->
            (div_limit[D_M2] == ((regs[`IDX_POWER_CTRL][`RATE_DOUBLE_BIT] && !frac_en)
                                 ? 16'h001f : 16'h003f));
    endproperty
    a_mode2_div: assert property (p_mode2_div) else $error("mode 2 divide wrong");

    property p_t2_select;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (serial_mode[0] && !frac_en && regs[`IDX_T2_CTRL][`T2_TX_CLK_BIT]
         && !regs[`IDX_T2_CTRL][`T2_RX_CLK_BIT]) |-> (tx_src == SRC_T2 && rx_src == SRC_T1);
    endproperty
    a_t2_select: assert property (p_t2_select) else $error("direction source wrong");

    property p_t1_post;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        div_limit[D_T1P] == ((regs[`IDX_POWER_CTRL][`RATE_DOUBLE_BIT] && !frac_en)
                             ? 16'h000f : 16'h001f);
    endproperty
    a_t1_post: assert property (p_t1_post) else $error("timer 1 post divide wrong");

    property p_t1_reload;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (t1_mode == 2'b10) |-> (div_limit[D_T1] + {8'h00, regs[`IDX_T1_RELOAD_HIGH]}
                                == 16'h00ff);
    endproperty
    a_t1_reload: assert property (p_t1_reload) else $error("timer 1 reload wrong");

    property p_t2_half;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (div_tick[D_T2P] && i_clk_en) |=> !div_tick[D_T2P];
    endproperty
    a_t2_half: assert property (p_t2_half) else $error("timer 2 stepped too fast");

    property p_frac_ignores;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        frac_en |-> (div_step[D_T2P] == 1'b0 && div_limit[D_M2] == 16'h003f &&
                     div_limit[D_T1P] == 16'h001f);
    endproperty
    a_frac_ignores: assert property (p_frac_ignores) else $error("doubling not ignored");

    property p_frac_bound;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_clk_en && div_tick[D_BIN] && !frac_wrap) |=> (frac_acc == $past(frac_acc) + 9'h002);
    endproperty
    a_frac_bound: assert property (p_frac_bound) else $error("fraction step wrong");

    property p_frac_tick;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (serial_mode[0] && frac_en && frac_tick) |=> (o_tick.tx && o_tick.rx);
    endproperty
    a_frac_tick: assert property (p_frac_tick) else $error("fraction tick lost");
endmodule

// [dv/shift_logic_model.sv]
// Model of the serial shift logic that times the bit-rate ticks it receives
module shift_logic_model (
    // Clock
    input  wire logic                    i_ref_clk,
    // Ticks from the generator
    input  wire baud_gen_pkg::bit_tick_s i_tick,
    // Last gap between ticks and running tick count, per direction
    output var  logic [31:0]             o_tx_gap,
    output var  logic [31:0]             o_rx_gap,
    output var  logic [31:0]             o_tx_cnt,
    output var  logic [31:0]             o_rx_cnt
);
    import baud_gen_pkg::*;
    logic [31:0] tx_age = 32'h0;
    logic [31:0] rx_age = 32'h0;

    initial begin
        o_tx_gap = 32'h0;
        o_rx_gap = 32'h0;
        o_tx_cnt = 32'h0;
        o_rx_cnt = 32'h0;
    end

    // ==========================================================
    // Each direction is timed apart, as the two may run at different rates
    always @(posedge i_ref_clk) begin
        tx_age <= i_tick.tx ? 32'h0 : tx_age + 32'h1;
        rx_age <= i_tick.rx ? 32'h0 : rx_age + 32'h1;
        if (i_tick.tx) begin
            o_tx_gap <= tx_age + 32'h1;
            o_tx_cnt <= o_tx_cnt + 32'h1;
        end
        if (i_tick.rx) begin
            o_rx_gap <= rx_age + 32'h1;
            o_rx_cnt <= o_rx_cnt + 32'h1;
        end
    end
endmodule

// [dv/tb.sv]
// Self-checking bench for the bit-rate generator, its registers and tick rates
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import baud_gen_pkg::*;

    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        t1_in     = 1'b1;
    logic        t1_toggle = 1'b0;
    logic        clk_en    = 1'b1;
    avs_req_s    avs       = '0;
    avs_rsp_s    rsp;
    bit_tick_s   tick;
    logic [31:0] tx_gap;
    logic [31:0] rx_gap;
    logic [31:0] tx_cnt;
    logic [31:0] rx_cnt;
    int          n_mismatch  = 0;
    int          checks_done = 0;
    int          cycles      = 0;

    always #2.5 i_ref_clk = ~i_ref_clk;

    baud_rate_gen u_dut (
        .i_ref_clk    (i_ref_clk),
        .i_sys_rst    (i_sys_rst),
        .i_clk_en     (clk_en),
        .i_avs        (avs),
        .o_avs        (rsp),
        .i_t1_count_in(t1_in),
        .o_tick       (tick)
    );

    shift_logic_model u_far (
        .i_ref_clk(i_ref_clk),
        .i_tick   (tick),
        .o_tx_gap (tx_gap),
        .o_rx_gap (rx_gap),
        .o_tx_cnt (tx_cnt),
        .o_rx_cnt (rx_cnt)
    );

    // ==========================================================
    // External count input toggles while t1_toggle is set, and the run is cut short on a hang
    always @(posedge i_ref_clk) begin
        t1_in  <= t1_toggle ? ~t1_in : 1'b1;
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One Avalon access: held until waitrequest is seen low at a rising edge
    task automatic bus(input logic rd, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge i_ref_clk);
        avs.read       <= rd;
        avs.write      <= ~rd;
        avs.address    <= a;
        avs.writedata  <= {24'h0, d};
        avs.byteenable <= 4'hf;
        // No local limit: only the bench timeout ends a wait that hangs
        do begin
            @(posedge i_ref_clk);
        end while (rsp.waitrequest !== 1'b0);
        q = rsp.readdata;
        avs.read  <= 1'b0;
        avs.write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 8'h00, q);
        chk(q, {24'h0, exp});
    endtask

    // Waits for three ticks each way, then compares the latest gaps
    task automatic rate(input logic [31:0] tx_exp, input logic [31:0] rx_exp);
        logic [31:0] tx0;
        logic [31:0] rx0;
        int          n;
        tx0 = tx_cnt;
        rx0 = rx_cnt;
        n = 0;
        while ((tx_cnt - tx0 < 3 || rx_cnt - rx0 < 3) && n < 12000) begin
            @(posedge i_ref_clk);
            n++;
        end
        chk({31'h0, n < 12000}, 32'h1);
        chk(tx_gap, tx_exp);
        chk(rx_gap, rx_exp);
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_regs();
        rd_chk(8'h20, 8'h00);
        wr(8'h20, 8'hff);
        rd_chk(8'h20, 8'h87);
        wr(8'h20, 8'h00);
        rd_chk(8'h30, 8'h00);
        rd_chk(8'h21, 8'h00);
        wr(8'h2c, 8'hff);
        rd_chk(8'h2c, 8'h00);
        $display("test regs done");
    endtask

    // Freeze just after a tick: no tx tick while held, mode 0 rate afterwards
    task automatic t_freeze();
        logic [31:0] c0;
        do begin
            @(posedge i_ref_clk);
        end while (tick.tx !== 1'b1);
        clk_en <= 1'b0;
        @(posedge i_ref_clk);
        c0 = tx_cnt;
        repeat (20) @(posedge i_ref_clk);
        chk(tx_cnt, c0);
        clk_en <= 1'b1;
        rate(32'd12, 32'd12);
        $display("test freeze done");
    endtask

    task automatic t_mode0();
        rate(32'd12, 32'd12);
        wr(8'h28, 8'h01);
        rate(32'd24, 32'd24);
        wr(8'h28, 8'h00);
        $display("test mode0 done");
    endtask

    task automatic t_mode2();
        wr(8'h00, 8'h80);
        rate(32'd64, 32'd64);
        wr(8'h04, 8'h80);
        rate(32'd32, 32'd32);
        rd_chk(8'h2c, 8'h09);
        $display("test mode2 done");
    endtask

    task automatic t_timer1();
        wr(8'h04, 8'h00);
        wr(8'h08, 8'h20);
        wr(8'h0c, 8'hfe);
        wr(8'h10, 8'h01);
        wr(8'h00, 8'h40);
        rate(32'd768, 32'd768);
        wr(8'h04, 8'h80);
        rate(32'd384, 32'd384);
        rd_chk(8'h2c, 8'h12);
        t1_toggle <= 1'b1;
        wr(8'h08, 8'h60);
        rate(32'd64, 32'd64);
        t1_toggle <= 1'b0;
        wr(8'h08, 8'h20);
        $display("test timer1 done");
    endtask

    task automatic t_timer2();
        wr(8'h18, 8'hfe);
        wr(8'h1c, 8'hff);
        wr(8'h14, 8'h14);
        rate(32'd64, 32'd384);
        rd_chk(8'h2c, 8'h13);
        wr(8'h14, 8'h34);
        rate(32'd64, 32'd64);
        wr(8'h00, 8'hc0);
        rate(32'd64, 32'd64);
        $display("test timer2 done");
    endtask

    task automatic t_frac();
        wr(8'h24, 8'h00);
        wr(8'h20, 8'h81);
        rate(32'd64, 32'd64);
        rd_chk(8'h2c, 8'h24);
        wr(8'h20, 8'h80);
        rate(32'd32, 32'd32);
        wr(8'h00, 8'h80);
        rate(32'd64, 32'd64);
        wr(8'h20, 8'h00);
        rate(32'd32, 32'd32);
        $display("test frac done");
    endtask

    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        t_regs();
        t_freeze();
        t_mode0();
        t_mode2();
        t_timer1();
        t_timer2();
        t_frac();
        give_verdict();
    end
endmodule
